/* File: gpio_expander_8ch_logic_map.vh */
`ifndef GPIO_EXPANDER_8CH_LOGIC_MAP_VH
`define GPIO_EXPANDER_8CH_LOGIC_MAP_VH

`define OFS_PIN_DATA 8'h00
`define OFS_PIN_DIRECTION 8'h01
`define OFS_PULLUP_ENABLE 8'h02
`define OFS_PULLDOWN_ENABLE 8'h03
`define OFS_RESERVED_SLOT 8'h04
`define OFS_IRQ_MASK 8'h05
`define OFS_EDGE_SENSE_UPPER 8'h06
`define OFS_EDGE_SENSE_LOWER 8'h07
`define OFS_IRQ_SOURCE_FLAGS 8'h08
`define OFS_EDGE_EVENT_FLAGS 8'h09
`define OFS_LOGIC_MODE_SELECT 8'h10
`define OFS_TRUTH_TABLE_ZERO 8'h11
`define OFS_TRUTH_TABLE_ONE 8'h12
`define OFS_TRUTH_TABLE_TWO 8'h13
`define OFS_TRUTH_TABLE_THREE 8'h14
`define OFS_TRUTH_TABLE_FOUR 8'h15
`define OFS_ADVANCED_SETTINGS 8'hab

`define RST_PIN_DATA 8'hff
`define RST_PIN_DIRECTION 8'hff
`define RST_PULLUP_ENABLE 8'h00
`define RST_PULLDOWN_ENABLE 8'h00
`define RST_IRQ_MASK 8'hff
`define RST_EDGE_SENSE 8'h00
`define RST_FLAGS 8'h00
`define RST_LOGIC_MODE 8'h00
`define RST_TRUTH_TABLE 8'h00
`define RST_ADVANCED 8'h00

`define UPPER_MODE_HI 5
`define UPPER_MODE_LO 4
`define LOWER_MODE_HI 1
`define LOWER_MODE_LO 0
`define BOOST_BIT 1

`define MODE_PLAIN 2'h0
`define MODE_TWO_TO_ONE 2'h1
`define MODE_THREE_TO_ONE 2'h2
`define MODE_THREE_TO_TWO 2'h3

`define SENSE_RISE_BIT 0
`define SENSE_FALL_BIT 1

// bus address is arbitrary
`define SERIAL_DEV_ADDR 7'h2a

`endif

/* File: gpio_expander_8ch_logic.v */
`timescale 1ns/1ps
`include "gpio_expander_8ch_logic_map.vh"

// Overview of operation
// - data writes set output levels; data reads return actual pin levels.
// - direction bit 0 makes output, 1 input; reset gives all inputs.
// - pull-up enable bit 1 turns pull-up on; reset turns all off.
// - pull-down enable bit 1 turns pull-down on; reset turns all off.
// - mask 0 lets line events raise interrupt; 1 blocks; reset masks all.
// - two-bit sense per line: none, rising, falling, both; upper/lower registers.
// - matching edge sets the line's event status bit.
// - matching edge on unmasked line sets interrupt source bit.
// - writing 1 to source bit clears it and the event bit.
// - interrupt output released once all source bits are clear.
// - writing 1 to event bit clears it and the source bit.
// - changing a line's sense setting clears that line's flags.
// - upper mode: plain, line 6 from 5..4, line 7 from 6..4.
// - lower mode: plain, line 2, line 3, or lines 4 and 3 decoded.
// - two-input decode picks table zero nibble bit by input value.
// - three-input decode picks table bit at input value index.
// - three-to-two: line 4 from table three, line 3 from four.
// - tables act only while their mode is selected.
// - logic function lines get direction automatically; others stay normal.
module gpio_expander_8ch_logic #(
   parameter LINES = 8
) (
   input wire mclk,
   input wire rst_b,
   input wire ce,
   input wire scl_in,
   input wire sda_in,
   output wire sda_out,
   output reg sda_oe,
   input wire [LINES-1:0] io_in,
   output reg [LINES-1:0] io_out,
   output reg [LINES-1:0] io_oe,
   output wire [LINES-1:0] pullup_on,
   output wire [LINES-1:0] pulldown_on,
   output wire boost_on,
   output wire irq_out_low,
   output reg irq_out_low_oe
);

   localparam [8:0] ST_IDLE = 9'h001;
   localparam [8:0] ST_ADDR = 9'h002;
   localparam [8:0] ST_ACK_ADDR = 9'h004;
   localparam [8:0] ST_REG = 9'h008;
   localparam [8:0] ST_ACK_REG = 9'h010;
   localparam [8:0] ST_WDATA = 9'h020;
   localparam [8:0] ST_ACK_W = 9'h040;
   localparam [8:0] ST_RDATA = 9'h080;
   localparam [8:0] ST_RACK = 9'h100;

   reg [7:0] data_q;
   reg [7:0] dir_q;
   reg [7:0] pu_q;
   reg [7:0] pd_q;
   reg [7:0] mask_q;
   reg [7:0] sense_hi_q;
   reg [7:0] sense_lo_q;
   reg [7:0] src_q;
   reg [7:0] ev_q;
   reg [7:0] mode_q;
   reg [7:0] tt0_q;
   reg [7:0] tt1_q;
   reg [7:0] tt2_q;
   reg [7:0] tt3_q;
   reg [7:0] tt4_q;
   reg [7:0] adv_q;
   reg [7:0] pins_prev_q;

   reg scl_q;
   reg sda_q;
   reg [8:0] state_q;
   reg [7:0] shift_q;
   reg [3:0] bitcnt_q;
   reg [7:0] ptr_q;
   reg rw_q;

   wire scl_rise = scl_in & ~scl_q;
   wire scl_fall = ~scl_in & scl_q;
   wire bus_start = scl_in & scl_q & sda_q & ~sda_in;
   wire bus_stop = scl_in & scl_q & ~sda_q & sda_in;
   wire byte_done = scl_fall & (bitcnt_q == 4'h8);

   // pins are open-drain style: only ever pulled low
   assign sda_out = 1'b0;
   assign irq_out_low = 1'b0;
   assign pullup_on = pu_q;
   assign pulldown_on = pd_q;
   assign boost_on = adv_q[`BOOST_BIT];

   wire wr_stb = ce & (state_q == ST_WDATA) & byte_done & ~bus_start & ~bus_stop;
   wire [7:0] wr_data = shift_q;

   reg [7:0] rd_data;
   always @* begin
      case (ptr_q)
         `OFS_PIN_DATA: rd_data = io_in;
         `OFS_PIN_DIRECTION: rd_data = dir_q;
         `OFS_PULLUP_ENABLE: rd_data = pu_q;
         `OFS_PULLDOWN_ENABLE: rd_data = pd_q;
         `OFS_IRQ_MASK: rd_data = mask_q;
         `OFS_EDGE_SENSE_UPPER: rd_data = sense_hi_q;
         `OFS_EDGE_SENSE_LOWER: rd_data = sense_lo_q;
         `OFS_IRQ_SOURCE_FLAGS: rd_data = src_q;
         `OFS_EDGE_EVENT_FLAGS: rd_data = ev_q;
         `OFS_LOGIC_MODE_SELECT: rd_data = mode_q;
         `OFS_TRUTH_TABLE_ZERO: rd_data = tt0_q;
         `OFS_TRUTH_TABLE_ONE: rd_data = tt1_q;
         `OFS_TRUTH_TABLE_TWO: rd_data = tt2_q;
         `OFS_TRUTH_TABLE_THREE: rd_data = tt3_q;
         `OFS_TRUTH_TABLE_FOUR: rd_data = tt4_q;
         `OFS_ADVANCED_SETTINGS: rd_data = adv_q;
         default: rd_data = 8'h00;
      endcase
   end

   // edge detection and flag bookkeeping
   reg [7:0] ev_set;
   reg [7:0] sense_chg;
   reg [7:0] w1c_src;
   reg [7:0] w1c_ev;
   reg [15:0] sense_all;
   reg [15:0] sense_new;
   reg [7:0] rise;
   reg [7:0] fall;
   integer i;
   always @* begin
      sense_all = {sense_hi_q, sense_lo_q};
      sense_new = sense_all;
      if (wr_stb && ptr_q == `OFS_EDGE_SENSE_UPPER) begin
         sense_new[15:8] = wr_data;
      end
      if (wr_stb && ptr_q == `OFS_EDGE_SENSE_LOWER) begin
         sense_new[7:0] = wr_data;
      end
      rise = io_in & ~pins_prev_q;
      fall = ~io_in & pins_prev_q;
      for (i = 0; i < 8; i = i + 1) begin
         ev_set[i] = (sense_all[2*i+`SENSE_RISE_BIT] & rise[i]) |
                     (sense_all[2*i+`SENSE_FALL_BIT] & fall[i]);
         sense_chg[i] = (sense_new[2*i+1 -: 2] != sense_all[2*i+1 -: 2]);
      end
      w1c_src = (wr_stb && ptr_q == `OFS_IRQ_SOURCE_FLAGS) ? wr_data : 8'h00;
      w1c_ev = (wr_stb && ptr_q == `OFS_EDGE_EVENT_FLAGS) ? wr_data : 8'h00;
   end

   // set wins over every clear so no edge is lost
   // event and source flag next state
   wire [7:0] ev_d = (ev_q & ~(w1c_src | w1c_ev | sense_chg)) | ev_set;
   wire [7:0] src_d = (src_q & ~(w1c_src | w1c_ev | sense_chg)) | (ev_set & ~mask_q);

   // logic function decode
   reg [7:0] pld_drive;
   reg [7:0] pld_input;
   reg [7:0] pld_val;
   wire [1:0] lo_mode = mode_q[`LOWER_MODE_HI:`LOWER_MODE_LO];
   wire [1:0] hi_mode = mode_q[`UPPER_MODE_HI:`UPPER_MODE_LO];
   always @* begin
      pld_drive = 8'h00;
      pld_input = 8'h00;
      pld_val = 8'h00;
      // tables used only in their mode
      case (lo_mode)
         `MODE_TWO_TO_ONE: begin
            pld_drive[2] = 1'b1;
            pld_input[1:0] = 2'h3;
            pld_val[2] = tt0_q[{1'b0, io_in[1:0]}];
         end
         `MODE_THREE_TO_ONE: begin
            pld_drive[3] = 1'b1;
            pld_input[2:0] = 3'h7;
            pld_val[3] = tt2_q[io_in[2:0]];
         end
         `MODE_THREE_TO_TWO: begin
            pld_drive[4:3] = 2'h3;
            pld_input[2:0] = 3'h7;
            pld_val[4] = tt3_q[io_in[2:0]];
            pld_val[3] = tt4_q[io_in[2:0]];
         end
         default: begin
            pld_drive[3:0] = 4'h0;
         end
      endcase
      // three-to-two owns line 4, so the upper field is then plain I/O
      if (lo_mode != `MODE_THREE_TO_TWO) begin
         case (hi_mode)
            `MODE_TWO_TO_ONE: begin
               pld_drive[6] = 1'b1;
               pld_input[5:4] = 2'h3;
               pld_val[6] = tt0_q[{1'b1, io_in[5:4]}];
            end
            `MODE_THREE_TO_ONE: begin
               pld_drive[7] = 1'b1;
               pld_input[6:4] = 3'h7;
               pld_val[7] = tt1_q[io_in[6:4]];
            end
            default: begin
               pld_drive[7:4] = 4'h0;
            end
         endcase
      end
   end

   // register file and pins
   always @(posedge mclk) begin
      if (!rst_b) begin
         data_q <= `RST_PIN_DATA;
         dir_q <= `RST_PIN_DIRECTION;
         pu_q <= `RST_PULLUP_ENABLE;
         pd_q <= `RST_PULLDOWN_ENABLE;
         mask_q <= `RST_IRQ_MASK;
         sense_hi_q <= `RST_EDGE_SENSE;
         sense_lo_q <= `RST_EDGE_SENSE;
         src_q <= `RST_FLAGS;
         ev_q <= `RST_FLAGS;
         mode_q <= `RST_LOGIC_MODE;
         tt0_q <= `RST_TRUTH_TABLE;
         tt1_q <= `RST_TRUTH_TABLE;
         tt2_q <= `RST_TRUTH_TABLE;
         tt3_q <= `RST_TRUTH_TABLE;
         tt4_q <= `RST_TRUTH_TABLE;
         adv_q <= `RST_ADVANCED;
         pins_prev_q <= 8'h00;
         io_out <= 8'h00;
         io_oe <= 8'h00;
         irq_out_low_oe <= 1'b0;
      end else if (ce) begin
         pins_prev_q <= io_in;
         ev_q <= ev_d;
         src_q <= src_d;
         irq_out_low_oe <= |src_d;
         sense_hi_q <= sense_new[15:8];
         sense_lo_q <= sense_new[7:0];
         io_oe <= pld_drive | (~pld_input & ~pld_drive & ~dir_q);
         io_out <= (pld_drive & pld_val) | (~pld_drive & data_q);
         if (wr_stb) begin
            case (ptr_q)
               `OFS_PIN_DATA: data_q <= wr_data;
               `OFS_PIN_DIRECTION: dir_q <= wr_data;
               `OFS_PULLUP_ENABLE: pu_q <= wr_data;
               `OFS_PULLDOWN_ENABLE: pd_q <= wr_data;
               `OFS_IRQ_MASK: mask_q <= wr_data;
               `OFS_LOGIC_MODE_SELECT: mode_q <= wr_data;
               `OFS_TRUTH_TABLE_ZERO: tt0_q <= wr_data;
               `OFS_TRUTH_TABLE_ONE: tt1_q <= wr_data;
               `OFS_TRUTH_TABLE_TWO: tt2_q <= wr_data;
               `OFS_TRUTH_TABLE_THREE: tt3_q <= wr_data;
               `OFS_TRUTH_TABLE_FOUR: tt4_q <= wr_data;
               `OFS_ADVANCED_SETTINGS: adv_q <= wr_data;
               default: adv_q <= adv_q;
            endcase
         end
      end
   end

   // two-wire serial slave; bus lines are sampled at mclk, far above bus rate
   always @(posedge mclk) begin
      if (!rst_b) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
         state_q <= ST_IDLE;
         shift_q <= 8'h00;
         bitcnt_q <= 4'h0;
         ptr_q <= 8'h00;
         rw_q <= 1'b0;
         sda_oe <= 1'b0;
      end else if (ce) begin
         scl_q <= scl_in;
         sda_q <= sda_in;
         if (bus_start) begin
            state_q <= ST_ADDR;
            bitcnt_q <= 4'h0;
            sda_oe <= 1'b0;
         end else if (bus_stop) begin
            state_q <= ST_IDLE;
            sda_oe <= 1'b0;
         end else begin
            case (state_q)
               ST_ADDR, ST_REG, ST_WDATA: begin
                  if (scl_rise && bitcnt_q != 4'h8) begin
                     shift_q <= {shift_q[6:0], sda_in};
                     bitcnt_q <= bitcnt_q + 4'h1;
                  end else if (byte_done) begin
                     bitcnt_q <= 4'h0;
                     if (state_q == ST_ADDR) begin
                        if (shift_q[7:1] == `SERIAL_DEV_ADDR) begin
                           rw_q <= shift_q[0];
                           sda_oe <= 1'b1;
                           state_q <= ST_ACK_ADDR;
                        end else begin
                           state_q <= ST_IDLE;
                        end
                     end else if (state_q == ST_REG) begin
                        ptr_q <= shift_q;
                        sda_oe <= 1'b1;
                        state_q <= ST_ACK_REG;
                     end else begin
                        sda_oe <= 1'b1;
                        state_q <= ST_ACK_W;
                     end
                  end
               end
               ST_ACK_ADDR: begin
                  if (scl_fall) begin
                     if (rw_q) begin
                        shift_q <= rd_data;
                        sda_oe <= ~rd_data[7];
                        state_q <= ST_RDATA;
                     end else begin
                        sda_oe <= 1'b0;
                        state_q <= ST_REG;
                     end
                  end
               end
               ST_ACK_REG: begin
                  if (scl_fall) begin
                     sda_oe <= 1'b0;
                     state_q <= ST_WDATA;
                  end
               end
               ST_ACK_W: begin
                  if (scl_fall) begin
                     // pointer advances so bursts fill consecutive registers
                     ptr_q <= ptr_q + 8'h01;
                     sda_oe <= 1'b0;
                     state_q <= ST_WDATA;
                  end
               end
               ST_RDATA: begin
                  if (scl_fall) begin
                     if (bitcnt_q == 4'h7) begin
                        bitcnt_q <= 4'h0;
                        sda_oe <= 1'b0;
                        ptr_q <= ptr_q + 8'h01;
                        state_q <= ST_RACK;
                     end else begin
                        bitcnt_q <= bitcnt_q + 4'h1;
                        shift_q <= {shift_q[6:0], 1'b0};
                        sda_oe <= ~shift_q[6];
                     end
                  end
               end
               ST_RACK: begin
                  if (scl_rise && sda_in) begin
                     state_q <= ST_IDLE;
                  end else if (scl_fall) begin
                     shift_q <= rd_data;
                     sda_oe <= ~rd_data[7];
                     state_q <= ST_RDATA;
                  end
               end
               default: begin
                  sda_oe <= 1'b0;
               end
            endcase
         end
      end
   end

endmodule

/* File: gpio_expander_8ch_logic_monitor.sv */
`timescale 1ns/1ps
module gpio_expander_8ch_logic_monitor #(
   parameter LINES = 8
) (
   input wire mclk,
   input wire rst_b,
   input wire ce,
   input wire scl_in,
   input wire sda_in,
   input wire sda_out,
   input wire sda_oe,
   input wire [LINES-1:0] io_in,
   input wire [LINES-1:0] io_out,
   input wire [LINES-1:0] io_oe,
   input wire [LINES-1:0] pullup_on,
   input wire [LINES-1:0] pulldown_on,
   input wire boost_on,
   input wire irq_out_low,
   input wire irq_out_low_oe
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_b);
   rst_quiet_a: assert property (
      $rose(rst_b) |-> io_oe == '0 && pullup_on == '0 && pulldown_on == '0 && !boost_on)
      else $error("pins not idle after reset");
   irq_pin_low_a: assert property (irq_out_low == 1'b0)
      else $error("irq pin level high");
   sda_pin_low_a: assert property (sda_out == 1'b0)
      else $error("data pin level high");
   // an interrupt needs a recent pin edge
   irq_cause_a: assert property (
      $rose(irq_out_low_oe) |-> $past(io_in) != $past(io_in, 2)
      || $past(io_in, 2) != $past(io_in, 3) || $past(io_in, 3) != $past(io_in, 4))
      else $error("irq without pin edge");
   irq_clear_a: assert property (
      $fell(irq_out_low_oe) |-> !scl_in && ($past(scl_in, 5) || $past(scl_in, 7)))
      else $error("irq released without write");
   ack_after_fall_a: assert property (
      $rose(sda_oe) |-> !scl_in && ($past(scl_in, 3) || $past(scl_in, 5)))
      else $error("data pulled low off clock fall");
   sda_steady_a: assert property (scl_in && $past(scl_in) |-> $stable(sda_oe))
      else $error("data moved while clock high");
   pins_on_write_a: assert property (
      $changed({io_oe, pullup_on, pulldown_on, boost_on}) |-> !scl_in
      && ($past(scl_in, 3) || $past(scl_in, 5) || $past(scl_in, 7)))
      else $error("pin setup moved without write");
   cover property ($rose(irq_out_low_oe));
   cover property ($fell(irq_out_low_oe));
   cover property ($rose(sda_oe));
endmodule
bind gpio_expander_8ch_logic gpio_expander_8ch_logic_monitor #(.LINES(LINES)) mon_i (
   .mclk(mclk), .rst_b(rst_b), .ce(ce), .scl_in(scl_in), .sda_in(sda_in),
   .sda_out(sda_out), .sda_oe(sda_oe), .io_in(io_in), .io_out(io_out), .io_oe(io_oe),
   .pullup_on(pullup_on), .pulldown_on(pulldown_on), .boost_on(boost_on),
   .irq_out_low(irq_out_low), .irq_out_low_oe(irq_out_low_oe));

/* File: serial_host_model.sv */
`timescale 1ns/1ps
`include "gpio_expander_8ch_logic_map.vh"
module serial_host_model (
   input wire mclk,
   input wire sda_oe,
   output reg scl = 1'b1,
   output wire sda
);
   reg sda_low = 1'b0;
   integer gap = 4;
   // open drain with pull-up: released line reads high
   assign sda = ~(sda_low | sda_oe);
   task half;
      repeat (gap) @(posedge mclk);
   endtask
   task sl(input v);
      begin
         half;
         sda_low <= v;
      end
   endtask
   task sc(input v);
      begin
         half;
         scl <= v;
      end
   endtask
   task start;
      begin
         sl(1'b0);
         sc(1'b1);
         sl(1'b1);
         sc(1'b0);
      end
   endtask
   task bit_io(input b, output r);
      begin
         sl(~b);
         sc(1'b1);
         half;
         r = sda;
         scl <= 1'b0;
      end
   endtask
   task xfer(input [7:0] tx, input ack_in, output [7:0] rx, output ack);
      integer i;
      reg r;
      begin
         for (i = 7; i >= 0; i = i - 1) begin
            bit_io(tx[i], r);
            rx = {rx[6:0], r};
         end
         bit_io(ack_in, ack);
      end
   endtask
   task wr(input [6:0] dev, input [7:0] ofs, input [39:0] d, input integer n, output a);
      reg [7:0] rx;
      reg k;
      integer i;
      begin
         start;
         xfer({dev, 1'b0}, 1'b1, rx, a);
         if (!a) begin
            xfer(ofs, 1'b1, rx, k);
            a = k;
            for (i = n - 1; i >= 0; i = i - 1) begin
               xfer(d[8*i +: 8], 1'b1, rx, k);
               a = a | k;
            end
         end
         sl(1'b1);
         sc(1'b1);
         sl(1'b0);
      end
   endtask
   task rd(input [7:0] ofs, output [7:0] d);
      reg [7:0] rx;
      reg k;
      begin
         start;
         xfer({`SERIAL_DEV_ADDR, 1'b0}, 1'b1, rx, k);
         xfer(ofs, 1'b1, rx, k);
         start;
         xfer({`SERIAL_DEV_ADDR, 1'b1}, 1'b1, rx, k);
         xfer(8'hff, 1'b1, d, k);
         sl(1'b1);
         sc(1'b1);
         sl(1'b0);
      end
   endtask
endmodule

/* File: test_gpio_expander_8ch_logic.sv */
`timescale 1ns/1ps
module test_gpio_expander_8ch_logic;
   reg mclk = 1'b0;
   reg rst_b = 1'b0;
   reg [7:0] ext = 8'h00;
   reg [7:0] t0, t1, t2, t3, t4;
   integer num_errors = 0;
   integer cmp_count = 0;
   integer cyc = 0;
   wire scl, sda, sda_out, sda_oe, boost_on, irq_out_low, irq_out_low_oe;
   wire [7:0] io_in, io_out, io_oe, pullup_on, pulldown_on;
   // a driven pad shows the block's level, others the outside level
   assign io_in = (io_oe & io_out) | (~io_oe & ext);
   always #20 mclk = ~mclk;
   gpio_expander_8ch_logic gpio_expander_8ch_logic_i (
      .mclk(mclk), .rst_b(rst_b), .ce(1'b1), .scl_in(scl), .sda_in(sda),
      .sda_out(sda_out), .sda_oe(sda_oe), .io_in(io_in), .io_out(io_out), .io_oe(io_oe),
      .pullup_on(pullup_on), .pulldown_on(pulldown_on), .boost_on(boost_on),
      .irq_out_low(irq_out_low), .irq_out_low_oe(irq_out_low_oe));
   serial_host_model serial_host_model_i (.mclk(mclk), .sda_oe(sda_oe), .scl(scl), .sda(sda));
   task finish_test;
      begin
         $display("errors %0d compares %0d", num_errors, cmp_count);
         if (num_errors == 0 && cmp_count > 0)
            $display("Regression OK");
         else
            $display("Regression broken");
         $finish;
      end
   endtask
   task chk(input [7:0] got, input [7:0] exp);
      begin
         cmp_count = cmp_count + 1;
         if (got !== exp) begin
            num_errors = num_errors + 1;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
         end
      end
   endtask
   task w(input [7:0] ofs, input [7:0] d);
      reg a;
      begin
         serial_host_model_i.wr(7'h2a, ofs, {32'h0, d}, 1, a);
         chk({7'h0, a}, 8'h00);
      end
   endtask
   task r(input [7:0] ofs, input [7:0] exp);
      reg [7:0] d;
      begin
         serial_host_model_i.rd(ofs, d);
         chk(d, exp);
      end
   endtask
   task tick(input [7:0] v);
      begin
         @(posedge mclk) ext <= v;
         repeat (4) @(posedge mclk);
      end
   endtask
   task reset_values;
      reg [255:0] rv;
      integer i;
      begin
         rv = 256'h01ff_0200_0300_0400_05ff_0600_0700_0800_0900_1000_1100_1200_1300_1400_1500_ab00;
         for (i = 0; i < 16; i = i + 1)
            r(rv[16*i+8 +: 8], rv[16*i +: 8]);
         w(8'h04, 8'hff);
         r(8'h04, 8'h00);
         w(8'h20, 8'h5a);
         r(8'h20, 8'h00);
      end
   endtask
   task pin_control;
      begin
         w(8'h01, 8'h0f);
         w(8'h00, 8'ha5);
         tick(8'h3c);
         chk(io_oe, 8'hf0);
         chk(io_out & 8'hf0, 8'ha0);
         r(8'h00, 8'hac);
         w(8'h02, 8'h81);
         w(8'h03, 8'h42);
         w(8'hab, 8'h02);
         chk(pullup_on, 8'h81);
         chk(pulldown_on, 8'h42);
         chk({7'h0, boost_on}, 8'h01);
         w(8'h01, 8'hff);
         tick(8'h00);
         chk(io_oe, 8'h00);
      end
   endtask
   // second reset with pulls set and every line driven, so the defaults are really reloaded
   task reset_again;
      begin
         w(8'h01, 8'h00);
         chk(io_oe, 8'hff);
         repeat (2) @(posedge mclk);
         rst_b <= 1'b0;
         repeat (5) @(posedge mclk);
         rst_b <= 1'b1;
         repeat (2) @(posedge mclk);
         chk(io_oe, 8'h00);
         chk(pullup_on, 8'h00);
         chk(pulldown_on, 8'h00);
         r(8'h01, 8'hff);
         r(8'h05, 8'hff);
      end
   endtask
   task edge_events;
      begin
         w(8'h05, 8'hfe);
         w(8'h07, 8'h39);
         w(8'h06, 8'h01);
         tick(8'h1f);
         chk({7'h0, irq_out_low_oe}, 8'h01);
         tick(8'h00);
         r(8'h09, 8'h17);
         r(8'h08, 8'h01);
         w(8'h08, 8'h01);
         chk({7'h0, irq_out_low_oe}, 8'h00);
         r(8'h09, 8'h16);
         w(8'h09, 8'h02);
         w(8'h09, 8'h00);
         r(8'h09, 8'h14);
         w(8'h06, 8'h02);
         r(8'h09, 8'h04);
         w(8'h05, 8'hfa);
         chk({7'h0, irq_out_low_oe}, 8'h00);
         w(8'h05, 8'hfe);
         tick(8'h01);
         chk({7'h0, irq_out_low_oe}, 8'h01);
         w(8'h09, 8'h01);
         r(8'h08, 8'h00);
         chk({7'h0, irq_out_low_oe}, 8'h00);
         w(8'h06, 8'h00);
         w(8'h07, 8'h00);
      end
   endtask
   task logic_modes;
      reg [7:0] m, oe, e;
      reg a;
      integer i, v;
      begin
         t0 = 8'h6a;
         t1 = 8'h96;
         t2 = 8'h3c;
         t3 = 8'he1;
         t4 = 8'h5a;
         serial_host_model_i.gap = 9;
         serial_host_model_i.wr(7'h2a, 8'h11, {t0, t1, t2, t3, t4}, 5, a);
         serial_host_model_i.gap = 4;
         chk({7'h0, a}, 8'h00);
         r(8'h15, t4);
         for (i = 0; i < 3; i = i + 1) begin
            m = (i == 0) ? 8'h11 : (i == 1) ? 8'h22 : 8'h13;
            oe = (i == 0) ? 8'h44 : (i == 1) ? 8'h88 : 8'h18;
            w(8'h10, m);
            for (v = 0; v < 8; v = v + 1) begin
               tick({1'b0, v[2:0], 1'b0, v[2:0]});
               case (i)
                  0: e = {1'b0, t0[4 + v[1:0]], 3'h0, t0[v[1:0]], 2'h0};
                  1: e = {t1[v], 3'h0, t2[v], 3'h0};
                  default: e = {3'h0, t3[v], t4[v], 3'h0};
               endcase
               chk(io_oe, oe);
               chk(io_out & oe, e);
            end
         end
         w(8'h10, 8'h00);
         chk(io_oe, 8'h00);
      end
   endtask
   initial begin
      repeat (5) @(posedge mclk);
      rst_b <= 1'b1;
      repeat (2) @(posedge mclk);
      reset_values;
      pin_control;
      reset_again;
      edge_events;
      logic_modes;
      finish_test;
   end
   // bus traffic of the whole run stays well below this ceiling
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         num_errors = num_errors + 1;
         finish_test;
      end
   end
endmodule
